// ### hw/power_meter_pa_alarms.sv
// Purpose: three interval power meters, a four stream running average meter and two alarms
// Assumes: samples arrive on pclk from the datapath, no synchronisers needed
// Notes:   apb slave with one wait state on every access
// Function
// - three interval meters: sum, max, two counts
// - fresh interval results set meter flag
// - each meter selects its own node
// - average meter: four streams, one node
// - exponential average with exponent 1..14
// - peaks above level counted per window
// - average meter can be gated
// - averages compared to high/low limits, two alarms
// - alarm mode off, average, peak, either
// - direction high, low or both
// - peak trip when count exceeds limit
// - every stream uses its own high/low limits
// - trip raises interrupt pin and flag
// - shared second action, per stream detection
// - action one selects backoff on high trip
// - backoff held until host clears alarm
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "power_meter_map.svh"
module power_meter_pa_alarms #(
   parameter int NODES   = 8,
   parameter int SW      = 15,
   parameter int STREAMS = 4,
   parameter int METERS  = 3
) (
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [11:0]              paddr,
   input  wire power_meter_pkg::word_t   pwdata,
   output logic                          pready,
   output power_meter_pkg::word_t        prdata,
   output logic                          pslverr,
   input  wire logic [NODES*SW-1:0]      node_i_bus,
   input  wire logic [NODES*SW-1:0]      node_q_bus,
   input  wire logic [NODES-1:0]         node_valid,
   input  wire logic [1:0]               node_stream,
   input  wire logic                     ra_gate,
   output logic [STREAMS-1:0]            cfr_gain_sel,
   output logic [STREAMS*16-1:0]         cfr_gain,
   output logic                          irq_out_pin
);
   import power_meter_pkg::*;
   localparam int PW = 2*SW+1;
   localparam int YW = PW+`PM_Y_FRAC;

   function automatic logic [PW-1:0] mag2(input logic signed [SW-1:0] i, input logic signed [SW-1:0] q);
      logic signed [2*SW-1:0] ii;
      logic signed [2*SW-1:0] qq;
      ii = i * i;
      qq = q * q;
      return {1'b0, ii} + {1'b0, qq};
   endfunction

   function automatic logic [PW-1:0] node_pow(input logic [2:0] idx, input logic [NODES*SW-1:0] ib,
                                              input logic [NODES*SW-1:0] qb);
      return mag2(ib[idx*SW +: SW], qb[idx*SW +: SW]);
   endfunction

   // apb: access phase holds one cycle, then completes with pready
   logic          pready_q;
   word_t         prdata_q;
   logic          pslverr_q;
   word_t         rd_d;
   logic          err_d;
   wire           acc_start = psel & penable & ~pready_q;
   wire           acc_done  = psel & penable & pready_q;
   wire           wr_en     = acc_done & pwrite;
   wire           rd_en     = acc_done & ~pwrite;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= acc_start;
         prdata_q  <= acc_start ? (pwrite ? 32'h0000_0000 : rd_d) : 32'h0000_0000;
         pslverr_q <= acc_start & err_d;
      end
   end
   assign pready  = pready_q;
   assign prdata  = prdata_q;
   assign pslverr = pslverr_q;

   // control registers
   logic [4:0]  stat_q, mask_q;
   logic [8:0]  alarm_cfg_q;
   word_t       peak_thr_q, peak_limit_q, peak_win_q;
   logic [16:0] ra_cfg_q;
   word_t       hi_q [STREAMS], lo_q [STREAMS];
   logic [15:0] gain_q [STREAMS];
   logic [2:0]  msel_q [METERS];
   word_t       mlen_q [METERS], mthr1_q [METERS], mthr2_q [METERS];
   logic [47:0] rsum_q [METERS];
   word_t       rmax_q [METERS];
   logic [15:0] rc1_q [METERS], rc2_q [METERS];
   logic [METERS-1:0] mdone;
   logic [YW-1:0]     y_q [STREAMS];
   word_t             wcnt_q [STREAMS], pcnt_q [STREAMS];
   logic [STREAMS-1:0] first_q, second_q, gsel_q;
   logic [STREAMS-1:0] first_cond, second_cond, hi_cause;
   logic               irq_q;

   wire alarm_mode_e first_mode  = alarm_mode_e'(alarm_cfg_q[`PM_FIRST_MODE_LSB +: 2]);
   wire alarm_mode_e second_mode = alarm_mode_e'(alarm_cfg_q[`PM_SECOND_MODE_LSB +: 2]);
   wire trip_dir_e   first_dir   = trip_dir_e'(alarm_cfg_q[`PM_FIRST_DIR_LSB +: 2]);
   wire trip_dir_e   second_dir  = trip_dir_e'(alarm_cfg_q[`PM_SECOND_DIR_LSB +: 2]);
   wire [2:0] ra_sel = ra_cfg_q[`PM_RA_SEL_LSB +: 3];
   wire [3:0] u_raw  = ra_cfg_q[`PM_RA_U_LSB +: 4];
   // out of range exponents clamp so the filter never stalls or overflows
   wire [3:0] u_eff  = (u_raw == 4'h0) ? 4'h1 : ((u_raw == 4'hF) ? 4'hE : u_raw);
   wire       trips_wr = wr_en & (paddr == `PM_TRIPS_OFS);
   wire [STREAMS-1:0] first_clr  = trips_wr ? pwdata[STREAMS-1:0] : '0;
   wire [STREAMS-1:0] second_clr = trips_wr ? pwdata[2*STREAMS-1:STREAMS] : '0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q       <= 5'h00;
         alarm_cfg_q  <= 9'h000;
         peak_thr_q   <= 32'hFFFF_FFFF;
         peak_limit_q <= 32'hFFFF_FFFF;
         peak_win_q   <= 32'h0000_0000;
         ra_cfg_q     <= 17'(`PM_RA_U_RESET) << `PM_RA_U_LSB;
      end else if (wr_en) begin
         if (paddr == `PM_MASK_OFS) mask_q <= pwdata[4:0];
         if (paddr == `PM_ALARM_CFG_OFS) alarm_cfg_q <= pwdata[8:0];
         if (paddr == `PM_PEAK_THR_OFS) peak_thr_q <= pwdata;
         if (paddr == `PM_PEAK_LIMIT_OFS) peak_limit_q <= pwdata;
         if (paddr == `PM_PEAK_WIN_OFS) peak_win_q <= pwdata;
         if (paddr == `PM_RA_CFG_OFS) ra_cfg_q <= pwdata[16:0];
      end
   end

   // interval meters
   genvar m;
   generate
      for (m = 0; m < METERS; m++) begin : g_meter
         logic [11:0] mb;
         logic [PW-1:0] p;
         logic        hit;
         word_t       icnt_q;
         logic [47:0] acc_q;
         word_t       mx_q;
         logic [15:0] c1_q, c2_q;
         logic        last;
         assign mb   = 12'(`PM_METER_BASE + m*`PM_METER_STRIDE);
         assign p    = node_pow(msel_q[m], node_i_bus, node_q_bus);
         assign hit  = node_valid[msel_q[m]] & (mlen_q[m] != 32'h0000_0000);
         assign last = hit & (icnt_q == mlen_q[m] - 32'h0000_0001);
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               msel_q[m]  <= 3'h0;
               mlen_q[m]  <= 32'h0000_0000;
               mthr1_q[m] <= 32'hFFFF_FFFF;
               mthr2_q[m] <= 32'hFFFF_FFFF;
            end else if (wr_en) begin
               if (paddr == mb + `PM_M_SEL) msel_q[m] <= pwdata[2:0];
               if (paddr == mb + `PM_M_LEN) mlen_q[m] <= pwdata;
               if (paddr == mb + `PM_M_THR1) mthr1_q[m] <= pwdata;
               if (paddr == mb + `PM_M_THR2) mthr2_q[m] <= pwdata;
            end
         end
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               icnt_q <= 32'h0000_0000;
               acc_q <= 48'h0000_0000_0000;
               mx_q <= 32'h0000_0000;
               c1_q <= 16'h0000;
               c2_q <= 16'h0000;
               rsum_q[m] <= 48'h0000_0000_0000;
               rmax_q[m] <= 32'h0000_0000;
               rc1_q[m] <= 16'h0000;
               rc2_q[m] <= 16'h0000;
               mdone[m] <= 1'b0;
            end else begin
               mdone[m] <= last;
               if (last) begin
                  // results include the closing sample; accumulators restart
                  rsum_q[m] <= acc_q + 48'(p);
                  rmax_q[m] <= (32'(p) > mx_q) ? 32'(p) : mx_q;
                  rc1_q[m] <= c1_q + 16'(32'(p) > mthr1_q[m]);
                  rc2_q[m] <= c2_q + 16'(32'(p) > mthr2_q[m]);
                  icnt_q <= 32'h0000_0000;
                  acc_q <= 48'h0000_0000_0000;
                  mx_q <= 32'h0000_0000;
                  c1_q <= 16'h0000;
                  c2_q <= 16'h0000;
               end else if (hit) begin
                  icnt_q <= icnt_q + 32'h0000_0001;
                  acc_q <= acc_q + 48'(p);
                  mx_q <= (32'(p) > mx_q) ? 32'(p) : mx_q;
                  c1_q <= c1_q + 16'(32'(p) > mthr1_q[m]);
                  c2_q <= c2_q + 16'(32'(p) > mthr2_q[m]);
               end
            end
         end
      end
   endgenerate

   // running average meter and alarms
   wire [PW-1:0] ra_p  = node_pow(ra_sel, node_i_bus, node_q_bus);
   wire          ra_on = node_valid[ra_sel] & (~ra_cfg_q[`PM_RA_GATE_BIT] | ra_gate);
   genvar s;
   generate
      for (s = 0; s < STREAMS; s++) begin : g_stream
         logic [11:0]   sb;
         logic          take, wend;
         logic [YW-1:0] y_next;
         word_t         avg;
         logic          over, under, pk;
         assign sb     = 12'(`PM_STREAM_BASE + s*`PM_STREAM_STRIDE);
         assign take   = ra_on & (node_stream == 2'(s));
         assign wend   = take & (wcnt_q[s] + 32'h0000_0001 >= peak_win_q);
         assign y_next = y_q[s] - (y_q[s] >> u_eff) + ({ra_p, `PM_Y_FRAC'(0)} >> u_eff);
         assign avg    = 32'(y_q[s][YW-1:`PM_Y_FRAC]);
         assign over   = avg > hi_q[s];
         assign under  = avg < lo_q[s];
         assign pk     = pcnt_q[s] > peak_limit_q;
         assign hi_cause[s] = over;
         assign first_cond[s] = (first_mode != ALM_OFF) &
            ((((first_mode == ALM_AVG) | (first_mode == ALM_EITHER)) &
              (((first_dir != DIR_LOW) & over) | ((first_dir != DIR_HIGH) & under))) |
             (((first_mode == ALM_PEAK) | (first_mode == ALM_EITHER)) & pk));
         assign second_cond[s] = (second_mode != ALM_OFF) &
            ((((second_mode == ALM_AVG) | (second_mode == ALM_EITHER)) &
              (((second_dir != DIR_LOW) & over) | ((second_dir != DIR_HIGH) & under))) |
             (((second_mode == ALM_PEAK) | (second_mode == ALM_EITHER)) & pk));
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               hi_q[s]   <= 32'hFFFF_FFFF;
               lo_q[s]   <= 32'h0000_0000;
               gain_q[s] <= `PM_GAIN_RESET;
            end else if (wr_en) begin
               if (paddr == sb + `PM_S_HIGH) hi_q[s] <= pwdata;
               if (paddr == sb + `PM_S_LOW) lo_q[s] <= pwdata;
               if (paddr == sb + `PM_S_GAIN) gain_q[s] <= pwdata[15:0];
            end
         end
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               y_q[s] <= '0;
               wcnt_q[s] <= 32'h0000_0000;
               pcnt_q[s] <= 32'h0000_0000;
               first_q[s] <= 1'b0;
               second_q[s] <= 1'b0;
               gsel_q[s] <= 1'b0;
            end else begin
               if (take) y_q[s] <= y_next;
               if (wend) begin
                  wcnt_q[s] <= 32'h0000_0000;
                  pcnt_q[s] <= 32'h0000_0000;
               end else if (take) begin
                  wcnt_q[s] <= wcnt_q[s] + 32'h0000_0001;
                  pcnt_q[s] <= pcnt_q[s] + 32'(32'(ra_p) > peak_thr_q);
               end
               // a live condition beats a clear in the same cycle
               first_q[s] <= first_cond[s] | (first_q[s] & ~first_clr[s]);
               second_q[s] <= second_cond[s] | (second_q[s] & ~second_clr[s]);
               gsel_q[s] <= (second_cond[s] & alarm_cfg_q[`PM_ACTION_BIT] & hi_cause[s] &
                             (second_dir != DIR_LOW) & (second_dir != DIR_RSVD) &
                             (second_mode != ALM_PEAK)) | (gsel_q[s] & ~second_clr[s]);
            end
         end
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cfr_gain[s*16 +: 16] <= `PM_GAIN_RESET;
            end else begin
               cfr_gain[s*16 +: 16] <= gain_q[s];
            end
         end
      end
   endgenerate
   assign cfr_gain_sel = gsel_q;

   // sticky status: a read clears only the bits it returned, so a late set is kept
   wire       stat_rd  = rd_en & (paddr == `PM_STATUS_OFS);
   wire       first_ev = |(first_cond & ~first_q);
   wire       second_ev = |(second_cond & ~second_q);
   wire [4:0] stat_set = {second_ev, first_ev, mdone};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_q <= 5'h00;
         irq_q <= 1'b0;
      end else begin
         stat_q <= stat_set | (stat_rd ? (stat_q & ~prdata_q[4:0]) : stat_q);
         irq_q <= |(stat_q & mask_q);
      end
   end
   assign irq_out_pin = irq_q;

   // read mux
   always_comb begin
      rd_d  = 32'h0000_0000;
      err_d = 1'b1;
      case (paddr)
         `PM_STATUS_OFS:     begin rd_d = 32'(stat_q);                   err_d = 1'b0; end
         `PM_MASK_OFS:       begin rd_d = 32'(mask_q);                   err_d = 1'b0; end
         `PM_TRIPS_OFS:      begin rd_d = 32'({second_q, first_q});      err_d = 1'b0; end
         `PM_GAINSEL_OFS:    begin rd_d = 32'(gsel_q);                   err_d = 1'b0; end
         `PM_ALARM_CFG_OFS:  begin rd_d = 32'(alarm_cfg_q);              err_d = 1'b0; end
         `PM_PEAK_THR_OFS:   begin rd_d = peak_thr_q;                    err_d = 1'b0; end
         `PM_PEAK_LIMIT_OFS: begin rd_d = peak_limit_q;                  err_d = 1'b0; end
         `PM_PEAK_WIN_OFS:   begin rd_d = peak_win_q;                    err_d = 1'b0; end
         `PM_RA_CFG_OFS:     begin rd_d = 32'(ra_cfg_q);                 err_d = 1'b0; end
         default: begin
         end
      endcase
      for (int k = 0; k < METERS; k++) begin
         for (int w = 0; w < 8; w++) begin
            if (paddr == 12'(`PM_METER_BASE + k*`PM_METER_STRIDE + w*4)) begin
               err_d = 1'b0;
               case (w)
                  0:       rd_d = 32'(msel_q[k]);
                  1:       rd_d = mlen_q[k];
                  2:       rd_d = mthr1_q[k];
                  3:       rd_d = mthr2_q[k];
                  4:       rd_d = rsum_q[k][31:0];
                  5:       rd_d = 32'(rsum_q[k][47:32]);
                  6:       rd_d = rmax_q[k];
                  default: rd_d = {rc2_q[k], rc1_q[k]};
               endcase
            end
         end
      end
      for (int k = 0; k < STREAMS; k++) begin
         for (int w = 0; w < 4; w++) begin
            if (paddr == 12'(`PM_STREAM_BASE + k*`PM_STREAM_STRIDE + w*4)) begin
               err_d = 1'b0;
               case (w)
                  0:       rd_d = hi_q[k];
                  1:       rd_d = lo_q[k];
                  2:       rd_d = 32'(gain_q[k]);
                  default: rd_d = 32'(y_q[k][YW-1:`PM_Y_FRAC]);
               endcase
            end
         end
      end
   end

   // checks
   a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
      |(stat_q & mask_q) |=> irq_out_pin) else $error("irq pin not raised");
   a_meter_flag: assert property (@(posedge pclk) disable iff (!presetn)
      mdone[0] |=> stat_q[0]) else $error("meter flag missing");
   a_first_latch: assert property (@(posedge pclk) disable iff (!presetn)
      first_cond[0] && !first_q[0] |=> first_q[0] && stat_q[3]) else $error("first trip not latched");
   a_mode_off: assert property (@(posedge pclk) disable iff (!presetn)
      first_mode == ALM_OFF |-> first_cond == '0) else $error("disabled alarm fired");
   a_peak_trip: assert property (@(posedge pclk) disable iff (!presetn)
      first_mode == ALM_PEAK && pcnt_q[1] > peak_limit_q |-> first_cond[1]) else $error("peak trip missed");
   a_u_range: assert property (@(posedge pclk) disable iff (!presetn)
      u_eff >= 4'h1 && u_eff <= 4'hE) else $error("exponent out of range");
   a_gain_needs: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(cfr_gain_sel[0]) |-> $past(alarm_cfg_q[`PM_ACTION_BIT]) && second_q[0]) else $error("bad backoff");
   a_gain_clear: assert property (@(posedge pclk) disable iff (!presetn)
      second_clr[0] && !second_cond[0] |=> !cfr_gain_sel[0]) else $error("backoff not released");
   a_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
      acc_start |=> pready ##1 !pready) else $error("apb wait wrong");
   a_avg_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !ra_on |=> $stable(y_q[2])) else $error("average moved while gated");
endmodule

// ### hw/power_meter_map.svh
// Purpose: register offsets, field positions and reset values of the power meter block
// Assumes: byte addresses on a 32-bit APB, one aligned word per register
// Notes:   definitions only
`ifndef POWER_METER_MAP_SVH
`define POWER_METER_MAP_SVH
`define PM_STATUS_OFS      12'h000
`define PM_MASK_OFS        12'h004
`define PM_TRIPS_OFS       12'h008
`define PM_GAINSEL_OFS     12'h00C
`define PM_ALARM_CFG_OFS   12'h040
`define PM_PEAK_THR_OFS    12'h044
`define PM_PEAK_LIMIT_OFS  12'h048
`define PM_PEAK_WIN_OFS    12'h04C
`define PM_RA_CFG_OFS      12'h050
`define PM_METER_BASE      12'h100
`define PM_METER_STRIDE    12'h020
`define PM_STREAM_BASE     12'h200
`define PM_STREAM_STRIDE   12'h010
// interval meter word offsets inside one meter
`define PM_M_SEL           12'h000
`define PM_M_LEN           12'h004
`define PM_M_THR1          12'h008
`define PM_M_THR2          12'h00C
`define PM_M_SUM_LO        12'h010
`define PM_M_SUM_HI        12'h014
`define PM_M_MAX           12'h018
`define PM_M_CNT           12'h01C
// per stream word offsets
`define PM_S_HIGH          12'h000
`define PM_S_LOW           12'h004
`define PM_S_GAIN          12'h008
`define PM_S_AVG           12'h00C
// alarm configuration fields
`define PM_FIRST_MODE_LSB  0
`define PM_SECOND_MODE_LSB 2
`define PM_FIRST_DIR_LSB   4
`define PM_SECOND_DIR_LSB  6
`define PM_ACTION_BIT      8
// running average configuration fields
`define PM_RA_SEL_LSB      0
`define PM_RA_U_LSB        8
`define PM_RA_GATE_BIT     16
`define PM_RA_U_RESET      4'hB
`define PM_Y_FRAC          14
`define PM_GAIN_RESET      16'hFFFF
`endif

// ### hw/power_meter_pkg.sv
// Purpose: shared types of the power meter block
// Assumes: nothing
// Notes:   encodings follow the alarm mode and trip direction fields
package power_meter_pkg;
   typedef enum logic [1:0] {ALM_OFF, ALM_AVG, ALM_PEAK, ALM_EITHER} alarm_mode_e;
   typedef enum logic [1:0] {DIR_HIGH, DIR_LOW, DIR_BOTH, DIR_RSVD} trip_dir_e;
   typedef logic [31:0] word_t;
endpackage

// ### sim/sample_source.sv
// Purpose: model of the datapath nodes that feed the power meters
// Assumes: one strobe per sample, stream tag valid with the strobe
// Notes:   buses are scrambled between strobes so stale samples never look valid
`timescale 1ns/1ps
module sample_source #(
   parameter int NODES = 8,
   parameter int SW    = 15
) (
   input  wire logic                pclk,
   output logic [NODES*SW-1:0]      node_i_bus,
   output logic [NODES*SW-1:0]      node_q_bus,
   output logic [NODES-1:0]         node_valid,
   output logic [1:0]               node_stream
);
   initial begin
      node_i_bus = '0;
      node_q_bus = '0;
      node_valid = '0;
      node_stream = '0;
   end
   task automatic send(input int node, input logic [1:0] strm, input logic [SW-1:0] i, input logic [SW-1:0] q);
      @(posedge pclk);
      node_i_bus[node*SW+:SW] <= i;
      node_q_bus[node*SW+:SW] <= q;
      node_valid[node] <= 1'b1;
      node_stream <= strm;
      @(posedge pclk);
      node_valid <= '0;
      node_i_bus <= ~node_i_bus;
      node_q_bus <= ~node_q_bus;
      node_stream <= ~strm;
   endtask
endmodule

// ### sim/power_meter_pa_alarms_tb.sv
// Purpose: self-checking bench for the power meter and alarm block
// Assumes: apb slave answers with a wait state, datapath side is the sample source model
// Notes:   exponent 1 gives exact averages; stream 1 high limit chosen one below its average
`timescale 1ns/1ps
`include "power_meter_map.svh"
module power_meter_pa_alarms_tb;
   import power_meter_pkg::*;
   logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, ra_gate, irq_out_pin;
   logic [11:0]         paddr;
   word_t               pwdata, prdata, rd;
   logic [8*15-1:0]     node_i_bus, node_q_bus;
   logic [7:0]          node_valid;
   logic [1:0]          node_stream;
   logic [3:0]          cfr_gain_sel;
   logic [63:0]         cfr_gain;
   logic                err;
   int                  miscompares, checks;

   power_meter_pa_alarms DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .node_i_bus(node_i_bus), .node_q_bus(node_q_bus), .node_valid(node_valid), .node_stream(node_stream),
      .ra_gate(ra_gate), .cfr_gain_sel(cfr_gain_sel), .cfr_gain(cfr_gain), .irq_out_pin(irq_out_pin));
   sample_source src (.pclk(pclk), .node_i_bus(node_i_bus), .node_q_bus(node_q_bus),
      .node_valid(node_valid), .node_stream(node_stream));

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   task automatic wrap_up();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input string name, input word_t got, input word_t exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   // request held until pready is sampled high, released only after that edge
   task automatic apb(input logic wr, input logic [11:0] a, input word_t wd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         miscompares++;
         wrap_up();
      end
   endtask

   task automatic wr(input logic [11:0] a, input word_t d);
      apb(1'b1, a, d);
   endtask

   task automatic rdchk(input string name, input logic [11:0] a, input word_t exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(name, rd, exp);
   endtask

   task automatic t_reset();
      chk("irq", {31'h0, irq_out_pin}, 32'h0000_0000);
      chk("gain_sel", {28'h0, cfr_gain_sel}, 32'h0000_0000);
      rdchk("status", `PM_STATUS_OFS, 32'h0000_0000);
      rdchk("trips", `PM_TRIPS_OFS, 32'h0000_0000);
      rdchk("ra_cfg", `PM_RA_CFG_OFS, 32'h0000_0B00);
      rdchk("avg0", `PM_STREAM_BASE + `PM_S_AVG, 32'h0000_0000);
      rdchk("gain0", `PM_STREAM_BASE + `PM_S_GAIN, 32'h0000_FFFF);
      apb(1'b0, 12'hFFC, 32'h0000_0000);
      chk("unmapped err", {31'h0, err}, 32'h0000_0001);
      $display("test reset done");
   endtask

   task automatic t_interval();
      wr(`PM_METER_BASE + `PM_M_SEL, 32'h0000_0001);
      wr(`PM_METER_BASE + `PM_M_THR1, 32'h0000_0014);
      wr(`PM_METER_BASE + `PM_M_THR2, 32'h0000_0032);
      wr(`PM_MASK_OFS, 32'h0000_001F);
      wr(`PM_METER_BASE + `PM_M_LEN, 32'h0000_0004);
      src.send(0, 2'd0, 15'd9, 15'd9);
      src.send(1, 2'd0, 15'd3, 15'd4);
      src.send(1, 2'd0, 15'd6, 15'd8);
      src.send(1, 2'd0, 15'd0, 15'd0);
      src.send(1, 2'd0, 15'd1, 15'd0);
      repeat (4) @(posedge pclk);
      chk("meter irq", {31'h0, irq_out_pin}, 32'h0000_0001);
      rdchk("sum", `PM_METER_BASE + `PM_M_SUM_LO, 32'h0000_007E);
      rdchk("max", `PM_METER_BASE + `PM_M_MAX, 32'h0000_0064);
      rdchk("cnt", `PM_METER_BASE + `PM_M_CNT, 32'h0001_0002);
      rdchk("status", `PM_STATUS_OFS, 32'h0000_0001);
      wr(`PM_METER_BASE + `PM_M_LEN, 32'h0000_0000);
      rdchk("status clr", `PM_STATUS_OFS, 32'h0000_0000);
      $display("test interval done");
   endtask

   task automatic t_average();
      wr(`PM_RA_CFG_OFS, 32'h0000_0102);
      wr(`PM_STREAM_BASE + `PM_STREAM_STRIDE + `PM_S_HIGH, 32'h0000_4E1F);
      wr(`PM_STREAM_BASE + `PM_STREAM_STRIDE + `PM_S_GAIN, 32'h0000_8000);
      wr(`PM_ALARM_CFG_OFS, 32'h0000_0105);
      src.send(2, 2'd0, 15'd100, 15'd0);
      src.send(2, 2'd1, 15'd0, 15'd200);
      repeat (3) @(posedge pclk);
      rdchk("avg0", `PM_STREAM_BASE + `PM_S_AVG, 32'h0000_1388);
      rdchk("avg1", `PM_STREAM_BASE + `PM_STREAM_STRIDE + `PM_S_AVG, 32'h0000_4E20);
      rdchk("trips", `PM_TRIPS_OFS, 32'h0000_0022);
      chk("gain_sel", {28'h0, cfr_gain_sel}, 32'h0000_0002);
      chk("gain", {16'h0, cfr_gain[31:16]}, 32'h0000_8000);
      chk("alarm irq", {31'h0, irq_out_pin}, 32'h0000_0001);
      rdchk("status", `PM_STATUS_OFS, 32'h0000_0018);
      wr(`PM_STREAM_BASE + `PM_STREAM_STRIDE + `PM_S_HIGH, 32'hFFFF_FFFF);
      wr(`PM_TRIPS_OFS, 32'h0000_0022);
      repeat (2) @(posedge pclk);
      chk("gain_sel clr", {28'h0, cfr_gain_sel}, 32'h0000_0000);
      rdchk("gainsel reg", `PM_GAINSEL_OFS, 32'h0000_0000);
      $display("test average done");
   endtask

   task automatic t_peak();
      wr(`PM_PEAK_THR_OFS, 32'h0000_03E8);
      wr(`PM_PEAK_LIMIT_OFS, 32'h0000_0001);
      wr(`PM_PEAK_WIN_OFS, 32'h0000_000A);
      wr(`PM_ALARM_CFG_OFS, 32'h0000_000E);
      src.send(2, 2'd2, 15'd100, 15'd0);
      repeat (3) @(posedge pclk);
      rdchk("one peak", `PM_TRIPS_OFS, 32'h0000_0000);
      src.send(2, 2'd2, 15'd0, 15'd100);
      repeat (3) @(posedge pclk);
      rdchk("two peaks", `PM_TRIPS_OFS, 32'h0000_0044);
      chk("no action", {28'h0, cfr_gain_sel}, 32'h0000_0000);
      wr(`PM_ALARM_CFG_OFS, 32'h0000_0000);
      wr(`PM_TRIPS_OFS, 32'h0000_00FF);
      rdchk("disabled", `PM_TRIPS_OFS, 32'h0000_0000);
      $display("test peak done");
   endtask

   task automatic t_gate();
      wr(`PM_RA_CFG_OFS, 32'h0001_0102);
      src.send(2, 2'd3, 15'd100, 15'd0);
      repeat (2) @(posedge pclk);
      rdchk("gated avg", 12'(`PM_STREAM_BASE + 3*`PM_STREAM_STRIDE + `PM_S_AVG), 32'h0000_0000);
      ra_gate <= 1'b1;
      src.send(2, 2'd3, 15'd100, 15'd0);
      repeat (2) @(posedge pclk);
      rdchk("open avg", 12'(`PM_STREAM_BASE + 3*`PM_STREAM_STRIDE + `PM_S_AVG), 32'h0000_1388);
      ra_gate <= 1'b0;
      $display("test gate done");
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      ra_gate = 1'b0;
      miscompares = 0;
      checks = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_interval();
      t_average();
      t_peak();
      t_gate();
      wrap_up();
   end
endmodule
